// ### plbf_defines.svh
// Constants for the link bring-up and fault block
`ifndef PLBF_DEFINES_SVH
`define PLBF_DEFINES_SVH

// ==========================================
// Register map (byte addresses)
`define PLBF_ADDR_CTRL 12'h000
`define PLBF_ADDR_STATUS 12'h004
`define PLBF_ADDR_LATCH 12'h008
`define PLBF_ADDR_PORT 12'h00C

// ==========================================
// Control fields
`define PLBF_CTRL_AN_EN 0
`define PLBF_CTRL_AN_RESTART 1
`define PLBF_CTRL_FEC_EN 2
`define PLBF_CTRL_FEC_PASS 3
`define PLBF_CTRL_TRAIN_DONE 4
`define PLBF_CTRL_CLR_LATCH 5
`define PLBF_CTRL_RESET 32'h0000_0001

// ==========================================
// XGMII characters
`define PLBF_CHAR_SEQ 8'h9C
`define PLBF_CHAR_ERR 8'hFE
`define PLBF_CHAR_IDLE 8'h07
`define PLBF_FAULT_LOCAL 8'h01
`define PLBF_FAULT_REMOTE 8'h02

// ==========================================
// Timing
`define PLBF_CLK_HZ 10000000
`define PLBF_TRAIN_MS 500
`define PLBF_TRAIN_CYC ((`PLBF_CLK_HZ / 1000) * `PLBF_TRAIN_MS)

`endif

// ### plbf_pkg.sv
// Types shared by the link bring-up and fault block
package plbf_pkg;

	// ==========================================
	// XGMII lane group, lane 0 in the low byte
	typedef struct packed {
		logic [63:0] data;
		logic [7:0] ctrl;
	} plbf_xgmii_t;

	// ==========================================
	// Negotiation sequencer states, Gray along the path
	typedef enum logic [2:0] {
		PLBF_ST_OFF = 3'b000,
		PLBF_ST_TX_DISABLE = 3'b001,
		PLBF_ST_AN_EXCHANGE = 3'b011,
		PLBF_ST_GOOD_CHECK = 3'b010,
		PLBF_ST_LINK_GOOD = 3'b110
	} plbf_an_state_t;

	// ==========================================
	// Transceiver receive mode
	typedef enum logic [1:0] {
		PLBF_MODE_NORMAL = 2'b00,
		PLBF_MODE_AN = 2'b01,
		PLBF_MODE_TRAIN = 2'b11
	} plbf_mode_t;

endpackage : plbf_pkg

// ### plbf_sync3.sv
// Three-stage synchroniser with second/third agreement
`timescale 1ns/1ps
module plbf_sync3 #(
	parameter int WIDTH = 1
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Data
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	typedef struct packed {
		logic [WIDTH-1:0] s1;
		logic [WIDTH-1:0] s2;
		logic [WIDTH-1:0] s3;
		logic [WIDTH-1:0] held;
	} plbf_sync_state_t;

	plbf_sync_state_t st;
	plbf_sync_state_t next_st;

	always_comb
	begin
		next_st = st;
		next_st.s1 = async_in;
		next_st.s2 = st.s1;
		next_st.s3 = st.s2;
		for (int i = 0; i < WIDTH; i++)
		begin
			// Only a level seen twice in a row counts
			if (st.s2[i] == st.s3[i])
			begin
				next_st.held[i] = st.s3[i];
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			st <= '0;
		end
		else
		begin
			st <= next_st;
		end
	end

	assign sync_out = st.held;
endmodule : plbf_sync3

// ### plbf_train_timer.sv
// Training deadline counter
`timescale 1ns/1ps
`include "plbf_defines.svh"
module plbf_train_timer #(
	parameter int CYCLES = `PLBF_TRAIN_CYC
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Control
	input wire logic restart,
	input wire logic run,
	output logic expired
);
	typedef struct packed {
		logic [31:0] count;
		logic done;
	} plbf_timer_state_t;

	plbf_timer_state_t st;
	plbf_timer_state_t next_st;

	always_comb
	begin
		next_st = st;
		if (restart)
		begin
			next_st = '0;
		end
		else if (run && !st.done)
		begin
			if (st.count == 32'(CYCLES - 1))
			begin
				next_st.done = 1'b1;
			end
			else
			begin
				next_st.count = st.count + 32'h0000_0001;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			st <= '0;
		end
		else
		begin
			st <= next_st;
		end
	end

	assign expired = st.done;
endmodule : plbf_train_timer

// ### plbf_core.sv
// Receive fault signalling, KR bring-up sequencing and error insertion
`timescale 1ns/1ps
`include "plbf_defines.svh"
module plbf_core #(
	parameter int TRAIN_CYCLES = `PLBF_TRAIN_CYC
) (
	// APB
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Pins from outside the clock domain
	input wire logic signal_detect,
	input wire logic [4:0] port_addr,
	// Receive path status from the decoder
	input wire logic block_lock,
	input wire logic high_error_rate_flag,
	input wire logic rx_error_state,
	input wire logic buf_underflow,
	input wire logic fec_uncorrectable,
	input wire logic [1:0] rx_sync_header,
	input wire plbf_pkg::plbf_xgmii_t rx_in,
	// Negotiation and training
	input wire logic an_frames_done,
	input wire logic train_complete,
	input wire logic far_train_request,
	// Management frame port address
	input wire logic [4:0] mgmt_frame_addr,
	input wire logic mgmt_frame_valid,
	// Outputs
	output plbf_pkg::plbf_xgmii_t rx_out,
	output logic [1:0] sync_header_out,
	output logic sync_forced_loss,
	output logic local_fault,
	output logic link_status,
	output logic tx_disable,
	output plbf_pkg::plbf_mode_t xcvr_mode,
	output logic link_good,
	output logic train_fail,
	output logic far_train_ack,
	output logic mgmt_respond
);
	typedef struct packed {
		logic [31:0] ctrl;
		logic [31:0] rdata;
		logic ready;
		logic err;
		logic lf_latch;
		logic ls_latch;
		plbf_pkg::plbf_an_state_t an;
		plbf_pkg::plbf_xgmii_t rxo;
		logic [1:0] sh;
		logic uflow_prev;
		logic lf;
		logic ls;
		logic nosync;
		logic tfail;
		logic ack;
		logic resp;
		logic txd;
		plbf_pkg::plbf_mode_t mode;
		logic lgood;
	} plbf_core_state_t;

	plbf_core_state_t st;
	plbf_core_state_t next_st;
	logic sig_ok;
	logic [4:0] port_sync;
	logic timer_expired;
	logic fault_seen;
	logic an_restart;
	logic apb_wr;
	logic apb_rd;

	// ==========================================
	// Pin synchronisers
	plbf_sync3 #(.WIDTH(1)) u_sig_sync (
		.pclk(pclk),
		.presetn(presetn),
		.async_in(signal_detect),
		.sync_out(sig_ok)
	);

	plbf_sync3 #(.WIDTH(5)) u_port_sync (
		.pclk(pclk),
		.presetn(presetn),
		.async_in(port_addr),
		.sync_out(port_sync)
	);

	// ==========================================
	// Training deadline
	assign an_restart = apb_wr && paddr == `PLBF_ADDR_CTRL && pwdata[`PLBF_CTRL_AN_RESTART];
	plbf_train_timer #(.CYCLES(TRAIN_CYCLES)) u_timer (
		.pclk(pclk),
		.presetn(presetn),
		.restart(an_restart || st.an == plbf_pkg::PLBF_ST_TX_DISABLE),
		.run(st.an == plbf_pkg::PLBF_ST_AN_EXCHANGE || st.an == plbf_pkg::PLBF_ST_GOOD_CHECK),
		.expired(timer_expired)
	);

	assign apb_wr = psel && penable && pwrite && st.ready;
	assign apb_rd = psel && penable && !pwrite && st.ready;
	assign fault_seen = rx_in.ctrl[0] && rx_in.data[7:0] == `PLBF_CHAR_SEQ;

	always_comb
	begin
		logic lf_now;
		logic ls_now;
		lf_now = 1'b0;
		ls_now = 1'b0;
		next_st = st;
		// ==========================================
		// APB slave, no wait states
		next_st.ready = psel && !penable && !st.ready;
		if (!psel)
		begin
			next_st.ready = 1'b0;
		end
		next_st.err = 1'b0;
		if (psel && !penable)
		begin
			case (paddr)
				`PLBF_ADDR_CTRL: next_st.rdata = st.ctrl;
				`PLBF_ADDR_STATUS: next_st.rdata = {26'h0, st.an, st.ls, st.lf, sig_ok};
				`PLBF_ADDR_LATCH: next_st.rdata = {30'h0, st.ls_latch, st.lf_latch};
				`PLBF_ADDR_PORT: next_st.rdata = {27'h0, port_sync};
				default:
				begin
					next_st.rdata = 32'h0000_0000;
					next_st.err = 1'b1;
				end
			endcase
		end
		if (apb_wr && paddr == `PLBF_ADDR_CTRL)
		begin
			next_st.ctrl = pwdata;
			next_st.ctrl[`PLBF_CTRL_AN_RESTART] = 1'b0;
			next_st.ctrl[`PLBF_CTRL_CLR_LATCH] = 1'b0;
		end
		// ==========================================
		// Fault and link status
		next_st.nosync = !sig_ok;
		lf_now = !sig_ok || !block_lock || high_error_rate_flag || st.uflow_prev;
		ls_now = !lf_now && !fault_seen;
		next_st.lf = lf_now;
		next_st.ls = ls_now;
		// Clear first, so a fault in the same cycle still latches
		if ((apb_rd && paddr == `PLBF_ADDR_LATCH) ||
			(apb_wr && paddr == `PLBF_ADDR_CTRL && pwdata[`PLBF_CTRL_CLR_LATCH]))
		begin
			next_st.lf_latch = 1'b0;
			next_st.ls_latch = 1'b1;
		end
		if (lf_now)
		begin
			next_st.lf_latch = 1'b1;
		end
		if (!ls_now)
		begin
			next_st.ls_latch = 1'b0;
		end
		// ==========================================
		// Receive data and error insertion
		next_st.sh = rx_sync_header;
		if (st.ctrl[`PLBF_CTRL_FEC_EN] && st.ctrl[`PLBF_CTRL_FEC_PASS] && fec_uncorrectable)
		begin
			next_st.sh = {rx_sync_header[0], rx_sync_header[0]};
		end
		next_st.uflow_prev = buf_underflow;
		if (buf_underflow && !st.uflow_prev)
		begin
			next_st.rxo.data = {8{`PLBF_CHAR_ERR}};
			next_st.rxo.ctrl = 8'hFF;
		end
		else if (lf_now)
		begin
			next_st.rxo.data = {32'h0, `PLBF_FAULT_LOCAL, 8'h00, 8'h00, `PLBF_CHAR_SEQ};
			next_st.rxo.ctrl = 8'h01;
		end
		else if (rx_error_state)
		begin
			next_st.rxo.data = {8{`PLBF_CHAR_ERR}};
			next_st.rxo.ctrl = 8'hFF;
		end
		else
		begin
			next_st.rxo = rx_in;
		end
		// ==========================================
		// KR negotiation sequencer
		case (st.an)
			plbf_pkg::PLBF_ST_OFF:
			begin
				if (st.ctrl[`PLBF_CTRL_AN_EN])
				begin
					next_st.an = plbf_pkg::PLBF_ST_TX_DISABLE;
				end
			end
			plbf_pkg::PLBF_ST_TX_DISABLE:
			begin
				next_st.tfail = 1'b0;
				next_st.an = plbf_pkg::PLBF_ST_AN_EXCHANGE;
			end
			plbf_pkg::PLBF_ST_AN_EXCHANGE:
			begin
				if (an_frames_done)
				begin
					next_st.an = plbf_pkg::PLBF_ST_GOOD_CHECK;
				end
			end
			plbf_pkg::PLBF_ST_GOOD_CHECK:
			begin
				if (train_complete || st.ctrl[`PLBF_CTRL_TRAIN_DONE])
				begin
					next_st.an = plbf_pkg::PLBF_ST_LINK_GOOD;
				end
				else if (timer_expired)
				begin
					next_st.tfail = 1'b1;
					next_st.an = plbf_pkg::PLBF_ST_TX_DISABLE;
				end
			end
			plbf_pkg::PLBF_ST_LINK_GOOD:
			begin
				if (!block_lock)
				begin
					next_st.an = plbf_pkg::PLBF_ST_TX_DISABLE;
				end
			end
			default: next_st.an = plbf_pkg::PLBF_ST_OFF;
		endcase
		if (an_restart)
		begin
			next_st.an = plbf_pkg::PLBF_ST_TX_DISABLE;
		end
		if (!st.ctrl[`PLBF_CTRL_AN_EN])
		begin
			next_st.an = plbf_pkg::PLBF_ST_OFF;
		end
		// Responder: acknowledge far-end training requests autonomously, in PLBF_ST_GOOD_CHECK only
		next_st.ack = far_train_request && st.an == plbf_pkg::PLBF_ST_GOOD_CHECK;
		next_st.resp = mgmt_frame_valid && mgmt_frame_addr == port_sync;
		// Decoded here so the sequencer outputs leave straight from flops
		next_st.txd = next_st.an == plbf_pkg::PLBF_ST_TX_DISABLE;
		next_st.lgood = next_st.an == plbf_pkg::PLBF_ST_LINK_GOOD;
		next_st.mode = next_st.an == plbf_pkg::PLBF_ST_AN_EXCHANGE ? plbf_pkg::PLBF_MODE_AN :
			next_st.an == plbf_pkg::PLBF_ST_GOOD_CHECK ? plbf_pkg::PLBF_MODE_TRAIN :
			plbf_pkg::PLBF_MODE_NORMAL;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			st <= '0;
			st.ctrl <= `PLBF_CTRL_RESET;
			st.lf <= 1'b1;
			st.lf_latch <= 1'b1;
			st.nosync <= 1'b1;
		end
		else
		begin
			st <= next_st;
		end
	end

	// ==========================================
	// Outputs
	assign prdata = st.rdata;
	assign pready = st.ready;
	assign pslverr = st.err;
	assign rx_out = st.rxo;
	assign sync_header_out = st.sh;
	assign sync_forced_loss = st.nosync;
	assign local_fault = st.lf;
	assign link_status = st.ls;
	assign tx_disable = st.txd;
	assign xcvr_mode = st.mode;
	assign link_good = st.lgood;
	assign train_fail = st.tfail;
	assign far_train_ack = st.ack;
	assign mgmt_respond = st.resp;

	// ==========================================
	// Checks
	a_nosig_fault: assert property (@(posedge pclk) disable iff (!presetn)
		!sig_ok |=> local_fault && !link_status)
		else $error("no signal without local fault");
	a_ls_on_lock: assert property (@(posedge pclk) disable iff (!presetn)
		!block_lock |=> !link_status)
		else $error("link up without block lock");
	a_sig_hold: assert property (@(posedge pclk) disable iff (!presetn)
		!sig_ok |=> sync_forced_loss)
		else $error("sync not forced lost");
	a_err_char: assert property (@(posedge pclk) disable iff (!presetn)
		rx_error_state && sig_ok && block_lock && !high_error_rate_flag && !buf_underflow
		&& !st.uflow_prev |=> rx_out.data[7:0] == `PLBF_CHAR_ERR && rx_out.ctrl[0])
		else $error("error char missing");
	a_fec_force: assert property (@(posedge pclk) disable iff (!presetn)
		st.ctrl[`PLBF_CTRL_FEC_EN] && st.ctrl[`PLBF_CTRL_FEC_PASS] && fec_uncorrectable
		|=> sync_header_out[0] == sync_header_out[1])
		else $error("fec error not forced");
	a_port_match: assert property (@(posedge pclk) disable iff (!presetn)
		mgmt_respond |-> $past(mgmt_frame_addr) == $past(port_sync))
		else $error("respond to wrong port");
	sequence s_disable_then_an;
		tx_disable ##1 xcvr_mode == plbf_pkg::PLBF_MODE_AN;
	endsequence
	a_kr_order: assert property (@(posedge pclk) disable iff (!presetn)
		tx_disable && !an_restart && st.ctrl[`PLBF_CTRL_AN_EN] |-> s_disable_then_an)
		else $error("negotiation did not follow disable");
	a_link_good: assert property (@(posedge pclk) disable iff (!presetn)
		st.an == plbf_pkg::PLBF_ST_GOOD_CHECK && train_complete && !an_restart
		&& st.ctrl[`PLBF_CTRL_AN_EN] |=> link_good)
		else $error("link good not set");
endmodule : plbf_core

// ### plbf_far_end.sv
// Far-end model: link partner, reconciliation layer and far trainer
`timescale 1ns/1ps
module plbf_far_end (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Bench controls
	input wire logic send_rf,
	input wire logic train_go,
	// Device side
	input wire logic local_fault,
	input wire plbf_pkg::plbf_xgmii_t rx_out,
	input wire logic far_train_ack,
	output plbf_pkg::plbf_xgmii_t rx_in,
	output logic far_train_request,
	output logic [8:0] rs_tx
);
	logic req_done;

	// ==========================================
	// Link partner: fault ordered sets or idles
	always_comb
	begin
		if (send_rf)
		begin
			rx_in.data = {2{8'h02, 8'h00, 8'h00, 8'h9C}};
			rx_in.ctrl = 8'h11;
		end
		else
		begin
			rx_in.data = {8{8'h07}};
			rx_in.ctrl = 8'hFF;
		end
	end

	// ==========================================
	// Reconciliation layer, lane 0 as {ctrl, char}
	always_comb
	begin
		if (local_fault)
			rs_tx = {1'b1, 8'h9C};
		else if (rx_out.ctrl[0] && rx_out.data[7:0] == 8'h9C)
			rs_tx = {1'b1, 8'h07};
		else
			rs_tx = 9'h0AA;
	end

	// ==========================================
	// Trainer: one command only, so no priority clash
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			far_train_request <= 1'b0;
			req_done <= 1'b0;
		end
		else
		begin
			far_train_request <= train_go && !req_done && !far_train_ack;
			req_done <= far_train_ack || (req_done && train_go);
		end
	end
endmodule : plbf_far_end

// ### test_plbf_core.sv
// Self-checking bench for the link bring-up and fault block
`timescale 1ns/1ps
`include "plbf_defines.svh"
`define CHK(nm, exp, got) \
	begin \
		comparisons++; \
		if ((got) !== (exp)) \
		begin \
			num_errors++; \
			$display("CHECK FAILED %s expected %0h seen %0h", nm, exp, got); \
		end \
	end
`define WAIT_FOR(cond) for (int i = 0; i < 200 && !(cond); i++) @(posedge pclk);
module test_plbf_core;
	localparam int TRAIN = 50;
	int num_errors = 0;
	int comparisons = 0;
	int cnt;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, r;
	logic signal_detect = 1'b0, block_lock = 1'b0, high_error_rate_flag = 1'b0;
	logic rx_error_state = 1'b0, buf_underflow = 1'b0, fec_uncorrectable = 1'b0;
	logic [1:0] rx_sync_header = 2'b01, sync_header_out;
	logic [4:0] port_addr = 5'h15, mgmt_frame_addr = 5'h00;
	logic an_frames_done = 1'b0, train_complete = 1'b0, mgmt_frame_valid = 1'b0;
	logic send_rf = 1'b0, train_go = 1'b0, far_train_request, far_train_ack;
	logic sync_forced_loss, local_fault, link_status, tx_disable, link_good, train_fail;
	logic mgmt_respond, rsp_err;
	logic [8:0] rs_tx;
	plbf_pkg::plbf_xgmii_t rx_in, rx_out;
	plbf_pkg::plbf_mode_t xcvr_mode;

	// ==========================================
	// Design and far end
	plbf_core #(.TRAIN_CYCLES(TRAIN)) u_plbf_core (.pclk, .presetn, .psel, .penable,
		.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .signal_detect, .port_addr,
		.block_lock, .high_error_rate_flag, .rx_error_state, .buf_underflow,
		.fec_uncorrectable, .rx_sync_header, .rx_in, .an_frames_done, .train_complete,
		.far_train_request, .mgmt_frame_addr, .mgmt_frame_valid, .rx_out, .sync_header_out,
		.sync_forced_loss, .local_fault, .link_status, .tx_disable, .xcvr_mode, .link_good,
		.train_fail, .far_train_ack, .mgmt_respond);
	plbf_far_end u_plbf_far_end (.pclk, .presetn, .send_rf, .train_go, .local_fault,
		.rx_out, .far_train_ack, .rx_in, .far_train_request, .rs_tx);

	always #50 pclk = ~pclk;

	// ==========================================
	// Tasks
	task automatic step(input int n);
		repeat (n) @(posedge pclk);
	endtask : step

	// Called just after an edge; request held until pready is seen
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		r = prdata;
		rsp_err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// One idle edge, so a following call never re-drives psel in this step
		@(posedge pclk);
	endtask : apb

	task automatic close_out();
		$display("comparisons %0d num_errors %0d", comparisons, num_errors);
		if (num_errors == 0 && comparisons > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : close_out

	initial
	begin
		step(4000);
		num_errors++;
		close_out();
	end

	// ==========================================
	// Tests
	initial
	begin
		step(2);
		presetn <= 1'b1;
		step(1);
		`CHK("local_fault", 1'b1, local_fault)
		`CHK("rs_tx", 9'h19C, rs_tx)
		`CHK("link_status", 1'b0, link_status)
		`CHK("sync_forced_loss", 1'b1, sync_forced_loss)
		apb(1'b0, `PLBF_ADDR_CTRL, 32'h0);
		`CHK("ctrl", 32'h1, r)
		apb(1'b0, 12'h010, 32'h0);
		`CHK("unmapped", 1'b1, rsp_err)
		apb(1'b0, `PLBF_ADDR_PORT, 32'h0);
		`CHK("port", 32'h15, r)
		for (int k = 0; k < 2; k++)
		begin
			mgmt_frame_addr <= 5'h14 + 5'(k);
			mgmt_frame_valid <= 1'b1;
			step(1);
			mgmt_frame_valid <= 1'b0;
			step(1);
			`CHK("mgmt_respond", 1'(k), mgmt_respond)
		end
		// Remote fault forwarded while link stays down
		signal_detect <= 1'b1;
		block_lock <= 1'b1;
		send_rf <= 1'b1;
		`WAIT_FOR(local_fault === 1'b0)
		step(2);
		`CHK("sync_forced_loss", 1'b0, sync_forced_loss)
		`CHK("rx_out", rx_in, rx_out)
		`CHK("link_status", 1'b0, link_status)
		`CHK("rs_tx", 9'h107, rs_tx)
		send_rf <= 1'b0;
		`WAIT_FOR(link_status === 1'b1)
		`CHK("link_status", 1'b1, link_status)
		`CHK("rs_tx", 9'h0AA, rs_tx)
		apb(1'b0, `PLBF_ADDR_STATUS, 32'h0);
		`CHK("status", 3'b101, r[2:0])
		apb(1'b0, `PLBF_ADDR_LATCH, 32'h0);
		`CHK("latch", 32'h1, r)
		apb(1'b0, `PLBF_ADDR_LATCH, 32'h0);
		`CHK("latch", 32'h2, r)
		block_lock <= 1'b0;
		step(3);
		`CHK("link_status", 1'b0, link_status)
		block_lock <= 1'b1;
		step(2);
		`CHK("local_fault", 1'b0, local_fault)
		high_error_rate_flag <= 1'b1;
		step(2);
		`CHK("local_fault", 1'b1, local_fault)
		high_error_rate_flag <= 1'b0;
		rx_error_state <= 1'b1;
		step(2);
		`CHK("err char", 9'h1FE, {rx_out.ctrl[0], rx_out.data[7:0]})
		rx_error_state <= 1'b0;
		buf_underflow <= 1'b1;
		step(2);
		`CHK("uflow", {{8{8'hFE}}, 8'hFF}, rx_out)
		step(1);
		`CHK("uflow lf", 33'h10100009C, {rx_out.ctrl[0], rx_out.data[31:0]})
		buf_underflow <= 1'b0;
		apb(1'b1, `PLBF_ADDR_CTRL, 32'hD);
		fec_uncorrectable <= 1'b1;
		step(2);
		`CHK("fec hdr", 1'b0, ^sync_header_out)
		fec_uncorrectable <= 1'b0;
		step(2);
		`CHK("fec hdr", 2'b01, sync_header_out)
		// KR bring-up
		apb(1'b1, `PLBF_ADDR_CTRL, 32'h3);
		`WAIT_FOR(tx_disable === 1'b1)
		`CHK("tx_disable", 1'b1, tx_disable)
		`WAIT_FOR(xcvr_mode === plbf_pkg::PLBF_MODE_AN)
		`CHK("mode", plbf_pkg::PLBF_MODE_AN, xcvr_mode)
		an_frames_done <= 1'b1;
		`WAIT_FOR(xcvr_mode === plbf_pkg::PLBF_MODE_TRAIN)
		`CHK("mode", plbf_pkg::PLBF_MODE_TRAIN, xcvr_mode)
		train_go <= 1'b1;
		`WAIT_FOR(far_train_ack === 1'b1)
		`CHK("far ack", 1'b1, far_train_ack)
		`WAIT_FOR(far_train_ack === 1'b0)
		`CHK("far ack", 1'b0, far_train_ack)
		train_complete <= 1'b1;
		`WAIT_FOR(link_good === 1'b1)
		`CHK("link_good", 1'b1, link_good)
		`CHK("mode", plbf_pkg::PLBF_MODE_NORMAL, xcvr_mode)
		train_complete <= 1'b0;
		// Frames stay done, so the deadline runs out in the training state
		apb(1'b1, `PLBF_ADDR_CTRL, 32'h3);
		`WAIT_FOR(tx_disable === 1'b1)
		`CHK("link_good", 1'b0, link_good)
		cnt = 0;
		while (train_fail !== 1'b1 && cnt < 4 * TRAIN)
		begin
			step(1);
			cnt++;
		end
		`CHK("deadline", 1'b1, cnt >= TRAIN - 3 && cnt <= TRAIN + 5)
		close_out();
	end
endmodule : test_plbf_core
